// ### dv/sar_adc_three_wire_readout_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define SAR_CHK(g, e, m) begin checked++; if ((g) !== (e)) begin \
  bad_count++; $display("MISMATCH t=%0t %s", $time, m); end end
// =============================================================
// Bench top: host model drives the link, a queue predicts results.
// =============================================================
module sar_adc_three_wire_readout_tb_top;
  import sar_pkg::*;
  logic                mclk = 1'b0;
  logic                rst = 1'b1;
  logic                convert_strobe, serial_clk, chain_din;
  logic [RESULT_W-1:0] conv_result = '0;
  logic                dout, dout_oe, cs_mode;
  logic                conv_active, power_down, sample_pulse;
  int                  bad_count = 0;
  int                  checked = 0;
  int                  exp_sp = 0;
  int                  sp_cnt = 0;
  int                  len = 0;
  int                  i;
  logic [RESULT_W-1:0] v;
  logic [RESULT_W-1:0] w;
  logic [RESULT_W-1:0] exp_q[$];

  // Free-running system clock.
  always #(CLK_PERIOD_NS / 2) mclk = ~mclk;

  sar_three_wire_top dut (.mclk(mclk), .rst(rst),
    .convert_strobe(convert_strobe), .serial_clk(serial_clk),
    .chain_din(chain_din), .conv_result(conv_result), .dout(dout),
    .dout_oe(dout_oe), .cs_mode(cs_mode), .conv_active(conv_active),
    .power_down(power_down), .sample_pulse(sample_pulse));

  sar_host_model host (.mclk(mclk), .dout(dout), .dout_oe(dout_oe),
    .convert_strobe(convert_strobe), .serial_clk(serial_clk),
    .chain_din(chain_din));

  // Watches power state, conversion starts and conversion length.
  always @(posedge mclk) begin
    if (!rst) begin
      `SAR_CHK(power_down, ~conv_active, "power state")
      if (sample_pulse === 1'b1) begin
        sp_cnt++;
        `SAR_CHK(dout_oe, 1'b0, "output driven at start")
      end
      if (conv_active === 1'b1) begin
        len++;
      end else if (len != 0) begin
        `SAR_CHK(len >= CONV_MIN_CYC && len <= CONV_MAX_CYC, 1'b1,
                 "length")
        len = 0;
      end
    end
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  // Presents a new core result and queues it as the expected word.
  task automatic load(input logic [RESULT_W-1:0] val);
    @(posedge mclk);
    conv_result <= val;
    exp_q.push_back(val);
  endtask : load

  // Raises the strobe with the chain pin at the given level.
  task automatic rise(input logic din);
    host.set_strobe(1'b1, din);
    exp_sp++;
  endtask : rise

  // Lets a started conversion finish and opens the readout.
  task automatic run_conv(input logic busy, input logic glitch);
    int n;
    if (busy) begin
      host.set_strobe(1'b0, 1'b1);
      for (n = 0; n < 60 && dout_oe !== 1'b1; n++) @(posedge mclk);
      `SAR_CHK(dout, 1'b0, "indicator bit")
    end else begin
      if (glitch) begin
        host.set_strobe(1'b0, 1'b1);
        host.set_strobe(1'b1, 1'b1);
      end
      repeat (45) @(posedge mclk);
      `SAR_CHK(dout_oe, 1'b0, "indicator while strobe high")
      host.set_strobe(1'b0, 1'b1);
      repeat (5) @(posedge mclk);
      `SAR_CHK(dout, exp_q[0][RESULT_W-1], "first bit")
    end
    `SAR_CHK({cs_mode, dout_oe, power_down}, 3'b111, "mode")
  endtask : run_conv

  // Reads a whole word and checks the release after the last fall.
  task automatic read_cmp(input logic busy);
    host.read(busy ? 17 : 16, busy, w);
    `SAR_CHK(w, exp_q.pop_front(), "result word")
    repeat (5) @(posedge mclk);
    `SAR_CHK(dout_oe, 1'b0, "release after last fall")
  endtask : read_cmp

  // Cuts a hung run short.
  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    wrap_up();
  end

  // Main sequence: full reads, early release, daisy mode.
  initial begin
    void'($urandom(32'h2DDCB8F8));
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    repeat (5) @(posedge mclk);
    `SAR_CHK({dout_oe, conv_active, power_down}, 3'b001, "reset")
    for (i = 0; i < 8; i++) begin
      v = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : 16'($urandom);
      load(v);
      rise(1'b1);
      run_conv(i[0], i == 2);
      read_cmp(i[0]);
    end
    for (i = 0; i < 2; i++) begin
      load(16'($urandom));
      rise(1'b1);
      run_conv(i[0], 1'b0);
      host.read(5, i[0], w);
      v = exp_q.pop_front();
      `SAR_CHK(w, i[0] ? v >> 12 : v >> 11, "partial word")
      load(16'($urandom));
      rise(1'b1);
      repeat (5) @(posedge mclk);
      `SAR_CHK(dout_oe, 1'b0, "early release")
      run_conv(1'b0, 1'b0);
      read_cmp(1'b0);
    end
    load(16'h5A5A);
    rise(1'b0);
    repeat (45) @(posedge mclk);
    `SAR_CHK(cs_mode, 1'b0, "daisy mode")
    host.set_strobe(1'b0, 1'b1);
    repeat (10) @(posedge mclk);
    `SAR_CHK(dout_oe, 1'b0, "no readout in daisy mode")
    void'(exp_q.pop_front());
    // Chain pin tied to the strobe: both rise together.
    host.set_strobe(1'b0, 1'b0);
    host.tie_rise();
    exp_sp++;
    repeat (45) @(posedge mclk);
    `SAR_CHK(cs_mode, 1'b0, "tied chain pin")
    host.set_strobe(1'b0, 1'b1);
    load(16'($urandom));
    rise(1'b1);
    run_conv(1'b1, 1'b0);
    read_cmp(1'b1);
    // Serial clock pulses outside a frame must not drive the line.
    host.read(2, 1'b0, w);
    `SAR_CHK({w, dout_oe}, 17'h00006, "clock outside a frame")
    repeat (40) @(posedge mclk);
    `SAR_CHK(sp_cnt, exp_sp, "conversion starts")
    wrap_up();
  end
endmodule : sar_adc_three_wire_readout_tb_top
`default_nettype wire

// ### dv/sar_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// =============================================================
// Host side of the three-wire link: strobe, serial clock, chain pin.
// =============================================================
module sar_host_model (
  input  wire logic mclk,
  input  wire logic dout,
  input  wire logic dout_oe,
  output logic      convert_strobe,
  output logic      serial_clk,
  output logic      chain_din
);
  logic line_w;

  // The data line has a pull-up, so a released line reads high.
  assign line_w = dout_oe ? dout : 1'b1;

  // Strobe idles low, the serial clock stands still low between frames.
  initial begin
    convert_strobe = 1'b0;
    serial_clk     = 1'b0;
    chain_din      = 1'b1;
  end

  // Sets the chain pin first, then moves the strobe a few cycles later.
  task automatic set_strobe(input logic lvl, input logic din);
    @(posedge mclk);
    chain_din <= din;
    repeat (4) @(posedge mclk);
    convert_strobe <= lvl;
  endtask : set_strobe

  // Reads nfall bits; each bit is latched just before its falling edge.
  task automatic read(input int nfall, input logic busy,
                      output logic [15:0] word);
    int   k;
    word = 16'h0000;
    for (k = 0; k < nfall; k++) begin
      @(posedge mclk);
      serial_clk <= 1'b1;
      repeat (4) @(posedge mclk);
      // A leading indicator bit is dropped from the word.
      if (!busy || k != 0) begin
        word = {word[14:0], line_w};
      end
      serial_clk <= 1'b0;
      // Low for four cycles, so the serial clock period is 160 ns.
      repeat (3) @(posedge mclk);
    end
  endtask : read

  // Moves the chain pin and the strobe together, as if tied.
  task automatic tie_rise();
    @(posedge mclk);
    chain_din      <= 1'b1;
    convert_strobe <= 1'b1;
  endtask : tie_rise
endmodule : sar_host_model
`default_nettype wire

// ### shared/sar_edge_if.sv
`timescale 1ns/1ns
`default_nettype none
// =============================================================
// Synchronised pin: level and one-cycle edge pulses.
// =============================================================
interface sar_edge_if;
  logic level;
  logic rise;
  logic fall;

  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface : sar_edge_if
`default_nettype wire

// ### shared/sar_pkg.sv
// =============================================================
// Shared constants for the converter control and readout block.
// =============================================================
package sar_pkg;

  // Width of one conversion result, straight unsigned binary.
  localparam int RESULT_W = 16;

  // Period of mclk in nanoseconds (50 MHz).
  localparam int CLK_PERIOD_NS = 20;

  // Conversion time bounds in nanoseconds.
  localparam int CONV_MIN_NS = 500;
  localparam int CONV_MAX_NS = 710;

  // Width of the conversion cycle counter.
  localparam int CNT_W = 6;

  // Least time rounds up, longest time rounds down.
  localparam logic [CNT_W-1:0] CONV_MIN_CYC =
    CNT_W'((CONV_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CONV_MAX_CYC =
    CNT_W'(CONV_MAX_NS / CLK_PERIOD_NS);

  // Number of distinct conversion lengths between the bounds.
  localparam logic [CNT_W-1:0] CONV_SPAN =
    CONV_MAX_CYC - CONV_MIN_CYC + CNT_W'(1);

  // Width of the dither generator and its reset seed.
  localparam int LFSR_W = 8;
  localparam logic [LFSR_W-1:0] LFSR_SEED = 8'hA5;

  // Width of the readout bit counter.
  localparam int BITS_W = 5;

  // Reset level of a synchronised pin.
  localparam logic PIN_RESET = 1'b0;

endpackage : sar_pkg

// ### verilog/sar_pin_sync.sv
`timescale 1ns/1ns
`default_nettype none
// =============================================================
// Two-flop pin synchroniser with edge detection.
// =============================================================
module sar_pin_sync
  import sar_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic pin_in,
  sar_edge_if.src   edge_o
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
  } sar_sync_t;

  localparam sar_sync_t SYNC_RESET = '{PIN_RESET, PIN_RESET, PIN_RESET};

  sar_sync_t st_r;
  sar_sync_t st_nxt;

  // The first flop feeds only the second; edges use the later ones.
  always_comb begin
    st_nxt      = st_r;
    st_nxt.meta = pin_in;
    st_nxt.sync = st_r.meta;
    st_nxt.last = st_r.sync;
  end

  // State register.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r <= SYNC_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Level and edge pulses seen by the control logic.
  assign edge_o.level = st_r.sync;
  assign edge_o.rise  = st_r.sync & ~st_r.last;
  assign edge_o.fall  = ~st_r.sync & st_r.last;

endmodule : sar_pin_sync
`default_nettype wire

// ### verilog/sar_three_wire_top.sv
`timescale 1ns/1ns
`default_nettype none
// =============================================================
// Conversion control and serial readout
// =============================================================
module sar_three_wire_top
  import sar_pkg::*;
#(
  parameter int DATA_W = RESULT_W
) (
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              convert_strobe,
  input  wire logic              serial_clk,
  input  wire logic              chain_din,
  input  wire logic [DATA_W-1:0] conv_result,
  output logic                   dout,
  output logic                   dout_oe,
  output logic                   cs_mode,
  output logic                   conv_active,
  output logic                   power_down,
  output logic                   sample_pulse
);

  // ===========================================================
  // Types and state
  // ===========================================================
  typedef enum logic [0:0] {
    ST_ACQ,
    ST_CONV
  } sar_state_t;

  typedef struct packed {
    sar_state_t         state;
    logic [CNT_W-1:0]   cnt;
    logic [LFSR_W-1:0]  lfsr;
    logic               cs_mode;
    logic               valid;
    logic               oe;
    logic [DATA_W:0]    shreg;
    logic [BITS_W-1:0]  bits;
    logic [DATA_W-1:0]  result;
    logic               sample;
  } sar_ctl_t;

  localparam sar_ctl_t CTL_RESET = '{
    state:   ST_ACQ,
    cnt:     '0,
    lfsr:    LFSR_SEED,
    cs_mode: 1'b1,
    valid:   1'b0,
    oe:      1'b0,
    shreg:   '1,
    bits:    '0,
    result:  '0,
    sample:  1'b0
  };

  sar_ctl_t st_r;
  sar_ctl_t st_nxt;

  // ===========================================================
  // Pin synchronisers
  // ===========================================================
  sar_edge_if strb_if ();
  sar_edge_if sclk_if ();
  sar_edge_if din_if ();

  sar_pin_sync u_strb_sync (
    .mclk   (mclk),
    .rst    (rst),
    .pin_in (convert_strobe),
    .edge_o (strb_if.src)
  );

  sar_pin_sync u_sclk_sync (
    .mclk   (mclk),
    .rst    (rst),
    .pin_in (serial_clk),
    .edge_o (sclk_if.src)
  );

  sar_pin_sync u_din_sync (
    .mclk   (mclk),
    .rst    (rst),
    .pin_in (chain_din),
    .edge_o (din_if.src)
  );

  // ===========================================================
  // Control logic
  // ===========================================================
  // Next state: conversion timing, mode capture and readout shifting.
  always_comb begin
    st_nxt        = st_r;
    st_nxt.sample = 1'b0;
    st_nxt.lfsr   = {st_r.lfsr[LFSR_W-2:0],
                     st_r.lfsr[7] ^ st_r.lfsr[5] ^
                     st_r.lfsr[4] ^ st_r.lfsr[3]};
    case (st_r.state)
      ST_ACQ: begin
        if (strb_if.rise) begin
          st_nxt.state   = ST_CONV;
          st_nxt.oe      = 1'b0;
          st_nxt.sample  = 1'b1;
          // The chain level just before the strobe edge picks the mode,
          // so a chain pin tied to the strobe reads as low.
          st_nxt.cs_mode = (din_if.level & ~din_if.rise) |
                           din_if.fall;
          // Dithered length keeps every conversion within bounds.
          st_nxt.cnt = CONV_MIN_CYC - CNT_W'(1) +
                       CNT_W'(st_r.lfsr % CONV_SPAN);
        end else if (st_r.cs_mode && st_r.valid) begin
          if (strb_if.fall && !st_r.oe) begin
            st_nxt.oe    = 1'b1;
            st_nxt.shreg = {st_r.result, 1'b1};
            st_nxt.bits  = BITS_W'(DATA_W);
          end else if (sclk_if.fall && st_r.oe) begin
            st_nxt.shreg = {st_r.shreg[DATA_W-1:0], 1'b1};
            st_nxt.bits  = st_r.bits - BITS_W'(1);
            if (st_r.bits == BITS_W'(1)) begin
              st_nxt.oe = 1'b0;
            end
          end
        end
      end
      ST_CONV: begin
        // The strobe is not looked at until the count runs out.
        if (st_r.cnt == '0) begin
          st_nxt.state  = ST_ACQ;
          st_nxt.valid  = 1'b1;
          st_nxt.result = conv_result;
          if (st_r.cs_mode && !strb_if.level) begin
            st_nxt.oe    = 1'b1;
            st_nxt.shreg = {1'b0, conv_result};
            st_nxt.bits  = BITS_W'(DATA_W + 1);
          end else begin
            st_nxt.oe = 1'b0;
          end
        end else begin
          st_nxt.cnt = st_r.cnt - CNT_W'(1);
        end
      end
      default: begin
        st_nxt = CTL_RESET;
      end
    endcase
  end

  // State register.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r <= CTL_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs come straight from the state register.
  assign dout         = st_r.shreg[DATA_W];
  assign dout_oe      = st_r.oe;
  assign cs_mode      = st_r.cs_mode;
  assign conv_active  = (st_r.state == ST_CONV);
  assign power_down   = (st_r.state == ST_ACQ);
  assign sample_pulse = st_r.sample;

  // ===========================================================
  // Checks
  // ===========================================================
  // Cycles spent converting, for the length check.
  logic [CNT_W-1:0] conv_len_r;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      conv_len_r <= '0;
    end else if (st_r.state == ST_CONV) begin
      conv_len_r <= conv_len_r + CNT_W'(1);
    end else begin
      conv_len_r <= '0;
    end
  end

  property p_start_conv;
    @(posedge mclk) disable iff (rst)
    (st_r.state == ST_ACQ && strb_if.rise)
      |=> (conv_active && !dout_oe && sample_pulse);
  endproperty
  a_start_conv: assert property (p_start_conv)
    else $error("Strobe rise did not start a conversion.");

  property p_cs_select;
    @(posedge mclk) disable iff (rst)
    (st_r.state == ST_ACQ && strb_if.rise && din_if.level && !din_if.rise)
      |=> cs_mode;
  endproperty
  a_cs_select: assert property (p_cs_select)
    else $error("Chip-select mode not selected.");

  property p_dc_select;
    @(posedge mclk) disable iff (rst)
    (st_r.state == ST_ACQ && strb_if.rise &&
     (din_if.rise || (!din_if.level && !din_if.fall))) |=> !cs_mode;
  endproperty
  a_dc_select: assert property (p_dc_select)
    else $error("Daisy-chain mode not selected.");

  property p_conv_holds;
    @(posedge mclk) disable iff (rst)
    (conv_active && st_r.cnt != '0) |=> conv_active;
  endproperty
  a_conv_holds: assert property (p_conv_holds)
    else $error("Conversion ended early.");

  property p_conv_len;
    @(posedge mclk) disable iff (rst)
    (conv_active && st_r.cnt == '0) |->
      (conv_len_r + CNT_W'(1) >= CONV_MIN_CYC &&
       conv_len_r + CNT_W'(1) <= CONV_MAX_CYC);
  endproperty
  a_conv_len: assert property (p_conv_len)
    else $error("Conversion length out of bounds.");

  property p_done_pd;
    @(posedge mclk) disable iff (rst)
    (conv_active && st_r.cnt == '0)
      |=> (power_down && st_r.result == $past(conv_result));
  endproperty
  a_done_pd: assert property (p_done_pd)
    else $error("Completion did not power down with the result.");

  property p_no_busy;
    @(posedge mclk) disable iff (rst)
    (conv_active && st_r.cnt == '0 && strb_if.level) |=> !dout_oe;
  endproperty
  a_no_busy: assert property (p_no_busy)
    else $error("Indicator driven with strobe high.");

  property p_busy_bit;
    @(posedge mclk) disable iff (rst)
    (conv_active && st_r.cnt == '0 && cs_mode && !strb_if.level)
      |=> (dout_oe && !dout);
  endproperty
  a_busy_bit: assert property (p_busy_bit)
    else $error("Indicator bit not driven low.");

  property p_msb_out;
    @(posedge mclk) disable iff (rst)
    (power_down && !strb_if.rise && cs_mode && st_r.valid &&
     strb_if.fall && !dout_oe)
      |=> (dout_oe && dout == st_r.result[DATA_W-1]);
  endproperty
  a_msb_out: assert property (p_msb_out)
    else $error("MSB not presented on strobe fall.");

  property p_shift;
    @(posedge mclk) disable iff (rst)
    (power_down && !strb_if.rise && dout_oe && sclk_if.fall &&
     st_r.bits > BITS_W'(1))
      |=> (dout_oe && dout == $past(st_r.shreg[DATA_W-1]));
  endproperty
  a_shift: assert property (p_shift)
    else $error("Next bit not shifted on serial clock fall.");

  property p_last_off;
    @(posedge mclk) disable iff (rst)
    (power_down && !strb_if.rise && dout_oe && sclk_if.fall &&
     st_r.bits == BITS_W'(1)) |=> !dout_oe;
  endproperty
  a_last_off: assert property (p_last_off)
    else $error("Output not released after the last bit.");

  property p_busy_count;
    @(posedge mclk) disable iff (rst)
    (conv_active && st_r.cnt == '0 && cs_mode && !strb_if.level)
      |=> (st_r.bits == BITS_W'(DATA_W + 1));
  endproperty
  a_busy_count: assert property (p_busy_count)
    else $error("Busy readout not set for seventeen edges.");

  // Outside a readout the serial clock must leave the output alone.
  property p_sclk_idle;
    @(posedge mclk) disable iff (rst)
    (power_down && !dout_oe && !strb_if.fall)
      |=> (!dout_oe && $stable(st_r.shreg));
  endproperty
  a_sclk_idle: assert property (p_sclk_idle)
    else $error("Serial clock moved data outside a readout.");

endmodule : sar_three_wire_top
`default_nettype wire
